// ---- hdl/urg_pkg.sv ----
// Purpose: Shared constants and types of the up/down ramp generator.
// Assumes: 125 MHz clock; position kept in tenths of a percent of span.
// Notes:   Output level is expressed in microamps.
package urg_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int FLT_SLOW_US   = 10000;
   localparam int FLT_FAST_US   = 500;
   localparam int RST_FLT_US    = 30000;
   localparam int QUANT_US      = 100;
   localparam int TENTH_US      = 100000;
   localparam int FLT_SLOW_CYC  = FLT_SLOW_US * 1000 / CLK_PERIOD_NS;
   localparam int FLT_FAST_CYC  = FLT_FAST_US * 1000 / CLK_PERIOD_NS;
   localparam int RST_FLT_CYC   = RST_FLT_US * 1000 / CLK_PERIOD_NS;
   localparam int QUANT_CYC     = QUANT_US * 1000 / CLK_PERIOD_NS;
   localparam int QPT           = TENTH_US / QUANT_US;
   localparam int FS            = 1000;
   localparam int OVR           = 30;
   localparam int OUT_MAX_UA    = 20500;
   localparam int RANGE_MAX_UA  = 20000;
   localparam int OFS_MAX_UA    = 10000;
   localparam int SPAN_MIN_UA   = 5000;
   localparam int TIME_MIN      = 1;
   localparam int TIME_MAX      = 9999990;
   localparam int CNT_MAX       = 60999;
   localparam int PRE_MAX       = 256;
   localparam logic [1:0] MODE_INT = 2'h1;
   localparam logic [1:0] MODE_PUL = 2'h2;
   localparam logic [1:0] MODE_ENC = 2'h3;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_UPT  = 8'h04;
   localparam logic [7:0] REG_DNT  = 8'h08;
   localparam logic [7:0] REG_UPC  = 8'h0C;
   localparam logic [7:0] REG_DNC  = 8'h10;
   localparam logic [7:0] REG_PRE  = 8'h14;
   localparam logic [7:0] REG_PSET = 8'h18;
   localparam logic [7:0] REG_SLO  = 8'h1C;
   localparam logic [7:0] REG_SHI  = 8'h20;
   localparam logic [7:0] REG_POS  = 8'h24;
   localparam logic [7:0] REG_OUT  = 8'h28;
   localparam logic [7:0] REG_STAT = 8'h2C;
   localparam int CTRL_MODE  = 0;
   localparam int CTRL_FAST  = 2;
   localparam int CTRL_FRONT = 3;
   localparam int CTRL_OVR   = 4;
   localparam logic [4:0]  RST_CTRL = 5'h01;
   localparam logic [23:0] RST_TIME = 24'h000064;
   localparam logic [15:0] RST_CNT  = 16'h03E8;
   localparam logic [8:0]  RST_PRE  = 9'h001;
   localparam logic [10:0] RST_PSET = 11'h000;
   localparam logic [14:0] RST_SLO  = 15'h0FA0;
   localparam logic [14:0] RST_SHI  = 15'h4E20;
   typedef enum logic {URG_INIT, URG_RUN} urg_st_e;
   typedef logic [23:0] urg_cnt_t;
   typedef struct packed {
      logic       ovr;
      logic       front;
      logic       fast;
      logic [1:0] mode;
   } urg_ctrl_s;
   typedef struct packed {
      logic     s1;
      logic     s2;
      logic     q;
      urg_cnt_t cnt;
   } urg_flt_s;
   typedef struct packed {
      urg_st_e      st;
      urg_ctrl_s    ctrl;
      logic [23:0]  upt;
      logic [23:0]  dnt;
      logic [15:0]  upc;
      logic [15:0]  dnc;
      logic [8:0]   pre;
      logic [10:0]  pset;
      logic [14:0]  slo;
      logic [14:0]  shi;
      logic         wt;
      logic [31:0]  rdata;
      logic         bad;
      logic [2:0]   prev;
      urg_cnt_t     qc_up;
      urg_cnt_t     qc_dn;
      logic [34:0]  acc_up;
      logic [34:0]  acc_dn;
      logic [10:0]  pend_up;
      logic [10:0]  pend_dn;
      logic signed [11:0] pos;
      logic [15:0]  out_ua;
      logic         keep_ok;
   } urg_st_s;
endpackage

// ---- hdl/urg_filter.sv ----
// Purpose: Two-flop synchroniser and pulse-length qualifier for one input.
// Assumes: limit is steady for long stretches.
// Notes:   Output follows the input only after it differs for more than limit cycles.
`timescale 1ns/1ns
module urg_filter (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             din,
   input  wire urg_pkg::urg_cnt_t limit,
   output logic                  q
);
   urg_pkg::urg_flt_s s_q;
   urg_pkg::urg_flt_s s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.s1 = din;
      s_d.s2 = s_q.s1;
      if (s_q.s2 == s_q.q)
      begin
         s_d.cnt = '0;
      end
      else if (s_q.cnt >= limit)
      begin
         s_d.q   = s_q.s2;
         s_d.cnt = '0;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 24'h000001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign q = s_q.q;
endmodule

// ---- hdl/urg_top.sv ----
// Purpose: Up/down ramp generator core with an Avalon-MM register slave.
// Assumes: Pins are asynchronous; nonvolatile store sits on clk.
// Notes:   Position is in tenths of a percent; output level in microamps.
`timescale 1ns/1ns
module urg_top #(
   parameter int FLT_SLOW = urg_pkg::FLT_SLOW_CYC,
   parameter int FLT_FAST = urg_pkg::FLT_FAST_CYC,
   parameter int RST_FLT  = urg_pkg::RST_FLT_CYC,
   parameter int QUANT    = urg_pkg::QUANT_CYC
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic [7:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               up_in,
   input  wire logic               dn_in,
   input  wire logic               rst_in,
   input  wire logic               key_up,
   input  wire logic               key_dn,
   input  wire logic               pup_hold,
   input  wire logic               nv_valid,
   input  wire logic signed [11:0] nv_pos,
   output logic signed [11:0]      pos_out,
   output logic [15:0]             out_ua,
   output logic                    keep_ok
);
   urg_pkg::urg_st_s  s_q;
   urg_pkg::urg_st_s  s_d;
   logic [2:0]        raw;
   logic [2:0]        qual;
   urg_pkg::urg_cnt_t lim [3];
   logic              ev_up;
   logic              ev_dn;
   logic              rst_ev;
   logic [33:0]       n_up;
   logic [33:0]       n_dn;

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            r[8*b +: 8] = n[8*b +: 8];
      end
      return r;
   endfunction

   assign raw[0] = up_in | (s_q.ctrl.front & key_up);
   assign raw[1] = dn_in | (s_q.ctrl.front & key_dn);
   assign raw[2] = rst_in;
   assign lim[0] = s_q.ctrl.fast ? 24'(FLT_FAST) : 24'(FLT_SLOW);
   assign lim[1] = lim[0];
   assign lim[2] = 24'(RST_FLT);

   for (genvar i = 0; i < 3; i++)
   begin : g_flt
      urg_filter u_flt (
         .clk     (clk),
         .reset_n (reset_n),
         .din     (raw[i]),
         .limit   (lim[i]),
         .q       (qual[i])
      );
   end

   always_comb
   begin
      if (s_q.ctrl.mode == urg_pkg::MODE_INT)
      begin
         n_up = 34'(s_q.upt) * 34'(urg_pkg::QPT);
         n_dn = 34'(s_q.dnt) * 34'(urg_pkg::QPT);
      end
      else
      begin
         n_up = 34'(s_q.upc) * 34'(s_q.pre);
         n_dn = 34'(s_q.dnc) * 34'(s_q.pre);
      end
   end

   always_comb
   begin
      logic [31:0] wv;
      logic [14:0] lo;
      logic [14:0] hi;
      logic [14:0] mn;
      logic [14:0] mx;
      int          span_i;
      int          out_i;
      int          lo_lim;
      int          hi_lim;
      int          p;
      logic        rise_a;
      wv = wmerge(32'h00000000, avs_writedata, avs_byteenable);
      lo = s_q.slo;
      hi = s_q.shi;
      mn = 15'h0000;
      mx = 15'h0000;
      span_i = 0;
      out_i = 0;
      lo_lim = 0;
      hi_lim = 0;
      p = 0;
      rise_a = qual[0] & ~s_q.prev[0];
      s_d = s_q;
      ev_up = 1'b0;
      ev_dn = 1'b0;
      rst_ev = qual[2] & ~s_q.prev[2];
      s_d.prev = qual;
      // Bus: one wait cycle, then the access completes on the low-waitrequest edge.
      s_d.wt = 1'b1;
      if ((avs_read | avs_write) & s_q.wt)
      begin
         s_d.wt = 1'b0;
         s_d.rdata = 32'h00000000;
         if (avs_address == urg_pkg::REG_CTRL)
            s_d.rdata = 32'(s_q.ctrl);
         else if (avs_address == urg_pkg::REG_UPT)
            s_d.rdata = 32'(s_q.upt);
         else if (avs_address == urg_pkg::REG_DNT)
            s_d.rdata = 32'(s_q.dnt);
         else if (avs_address == urg_pkg::REG_UPC)
            s_d.rdata = 32'(s_q.upc);
         else if (avs_address == urg_pkg::REG_DNC)
            s_d.rdata = 32'(s_q.dnc);
         else if (avs_address == urg_pkg::REG_PRE)
            s_d.rdata = 32'(s_q.pre);
         else if (avs_address == urg_pkg::REG_PSET)
            s_d.rdata = 32'(s_q.pset);
         else if (avs_address == urg_pkg::REG_SLO)
            s_d.rdata = 32'(s_q.slo);
         else if (avs_address == urg_pkg::REG_SHI)
            s_d.rdata = 32'(s_q.shi);
         else if (avs_address == urg_pkg::REG_POS)
            s_d.rdata = 32'(signed'(s_q.pos));
         else if (avs_address == urg_pkg::REG_OUT)
            s_d.rdata = 32'(s_q.out_ua);
         else if (avs_address == urg_pkg::REG_STAT)
            s_d.rdata = {27'h0000000, s_q.keep_ok, s_q.bad, qual};
      end
      if (avs_write & ~s_q.wt)
      begin
         wv = wmerge(s_q.rdata, avs_writedata, avs_byteenable);
         if (avs_address == urg_pkg::REG_CTRL)
         begin
            // only the three function codes are taken.
            if (wv[urg_pkg::CTRL_MODE +: 2] != 2'h0)
               s_d.ctrl = urg_pkg::urg_ctrl_s'(wv[4:0]);
            else
               s_d.bad = 1'b1;
         end
         else if (avs_address == urg_pkg::REG_UPT || avs_address == urg_pkg::REG_DNT)
         begin
            // ramp time limits in tenths of a second.
            if (wv >= 32'(urg_pkg::TIME_MIN) && wv <= 32'(urg_pkg::TIME_MAX))
            begin
               if (avs_address == urg_pkg::REG_UPT)
                  s_d.upt = wv[23:0];
               else
                  s_d.dnt = wv[23:0];
            end
            else
               s_d.bad = 1'b1;
         end
         else if (avs_address == urg_pkg::REG_UPC || avs_address == urg_pkg::REG_DNC)
         begin
            // entered counts of 1 to 60999.
            if (wv >= 32'h00000001 && wv <= 32'(urg_pkg::CNT_MAX))
            begin
               if (avs_address == urg_pkg::REG_UPC)
                  s_d.upc = wv[15:0];
               else
                  s_d.dnc = wv[15:0];
            end
            else
               s_d.bad = 1'b1;
         end
         else if (avs_address == urg_pkg::REG_PRE)
         begin
            if (wv >= 32'h00000001 && wv <= 32'(urg_pkg::PRE_MAX))
               s_d.pre = wv[8:0];
            else
               s_d.bad = 1'b1;
         end
         else if (avs_address == urg_pkg::REG_PSET)
         begin
            // preset within 0 to 100 percent.
            if (wv <= 32'(urg_pkg::FS))
               s_d.pset = wv[10:0];
            else
               s_d.bad = 1'b1;
         end
         else if (avs_address == urg_pkg::REG_SLO || avs_address == urg_pkg::REG_SHI)
         begin
            if (avs_address == urg_pkg::REG_SLO)
               lo = wv[14:0];
            else
               hi = wv[14:0];
            mn = (lo < hi) ? lo : hi;
            mx = (lo < hi) ? hi : lo;
            if (wv <= 32'(urg_pkg::RANGE_MAX_UA) && mn <= 15'(urg_pkg::OFS_MAX_UA)
                && mx - mn >= 15'(urg_pkg::SPAN_MIN_UA))
            begin
               s_d.slo = lo;
               s_d.shi = hi;
            end
            else
               s_d.bad = 1'b1;
         end
         else if (avs_address == urg_pkg::REG_STAT)
         begin
            if (wv[3])
               s_d.bad = 1'b0;
         end
      end
      // Internal timing: one event per elapsed quantum while the input is held.
      if (s_q.ctrl.mode == urg_pkg::MODE_INT)
      begin
         // timers run only on qualified levels.
         s_d.qc_up = qual[0] ? s_q.qc_up + 24'h000001 : '0;
         s_d.qc_dn = qual[1] ? s_q.qc_dn + 24'h000001 : '0;
         if (qual[0] && s_q.qc_up >= 24'(QUANT - 1))
         begin
            s_d.qc_up = '0;
            ev_up = 1'b1;
         end
         if (qual[1] && s_q.qc_dn >= 24'(QUANT - 1))
         begin
            s_d.qc_dn = '0;
            ev_dn = 1'b1;
         end
      end
      else if (s_q.ctrl.mode == urg_pkg::MODE_PUL)
      begin
         // a held pulse shows as one qualified rising edge.
         ev_up = rise_a;
         ev_dn = qual[1] & ~s_q.prev[1];
      end
      else if (s_q.ctrl.mode == urg_pkg::MODE_ENC)
      begin
         // direction from phase B at phase A rising.
         ev_up = rise_a & ~qual[1];
         ev_dn = rise_a & qual[1];
      end
      // error accumulators turn events into exact position steps.
      s_d.acc_up = s_q.acc_up + (ev_up ? 35'(urg_pkg::FS) : 35'h000000000);
      s_d.acc_dn = s_q.acc_dn + (ev_dn ? 35'(urg_pkg::FS) : 35'h000000000);
      if (n_up != 34'h000000000 && s_q.acc_up >= 35'(n_up))
      begin
         s_d.acc_up = s_d.acc_up - 35'(n_up);
         s_d.pend_up = s_d.pend_up + 11'h001;
      end
      if (n_dn != 34'h000000000 && s_q.acc_dn >= 35'(n_dn))
      begin
         s_d.acc_dn = s_d.acc_dn - 35'(n_dn);
         s_d.pend_dn = s_d.pend_dn + 11'h001;
      end
      p = int'(s_q.pos);
      // opposing steps cancel, the net moves the position.
      if (s_q.pend_up != 11'h000 && s_q.pend_dn != 11'h000)
      begin
         s_d.pend_up = s_d.pend_up - 11'h001;
         s_d.pend_dn = s_d.pend_dn - 11'h001;
      end
      else if (s_q.pend_up != 11'h000)
      begin
         s_d.pend_up = s_d.pend_up - 11'h001;
         p = p + 1;
      end
      else if (s_q.pend_dn != 11'h000)
      begin
         s_d.pend_dn = s_d.pend_dn - 11'h001;
         p = p - 1;
      end
      case (s_q.st)
         urg_pkg::URG_INIT:
         begin
            // start from the kept value or the preset.
            p = (pup_hold & nv_valid) ? int'(nv_pos) : int'(s_q.pset);
            s_d.st = urg_pkg::URG_RUN;
         end
         urg_pkg::URG_RUN:
         begin
            if (rst_ev)
            begin
               p = int'(s_q.pset);
               s_d.acc_up = '0;
               s_d.acc_dn = '0;
               s_d.pend_up = '0;
               s_d.pend_dn = '0;
            end
         end
         default:
            s_d.st = urg_pkg::URG_INIT;
      endcase
      // clamp to span, or to span plus overrange.
      lo_lim = s_d.ctrl.ovr ? -urg_pkg::OVR : 0;
      hi_lim = s_d.ctrl.ovr ? urg_pkg::FS + urg_pkg::OVR : urg_pkg::FS;
      if (p < lo_lim)
         p = lo_lim;
      if (p > hi_lim)
         p = hi_lim;
      s_d.pos = 12'(p);
      span_i = int'(s_q.shi) - int'(s_q.slo);
      out_i = int'(s_q.slo) + span_i * int'(s_q.pos) / urg_pkg::FS;
      if (out_i < 0)
         out_i = 0;
      if (out_i > urg_pkg::OUT_MAX_UA)
         out_i = urg_pkg::OUT_MAX_UA;
      s_d.out_ua = 16'(out_i);
      // retention valid in timed mode or with prescaler 1.
      s_d.keep_ok = (s_q.ctrl.mode == urg_pkg::MODE_INT) || (s_q.pre == 9'h001);
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_q      <= '0;
         s_q.st   <= urg_pkg::URG_INIT;
         s_q.ctrl <= urg_pkg::RST_CTRL;
         s_q.upt  <= urg_pkg::RST_TIME;
         s_q.dnt  <= urg_pkg::RST_TIME;
         s_q.upc  <= urg_pkg::RST_CNT;
         s_q.dnc  <= urg_pkg::RST_CNT;
         s_q.pre  <= urg_pkg::RST_PRE;
         s_q.pset <= urg_pkg::RST_PSET;
         s_q.slo  <= urg_pkg::RST_SLO;
         s_q.shi  <= urg_pkg::RST_SHI;
         s_q.wt   <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign avs_readdata    = s_q.rdata;
   assign avs_waitrequest = s_q.wt;
   assign pos_out         = s_q.pos;
   assign out_ua          = s_q.out_ua;
   assign keep_ok         = s_q.keep_ok;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_filter_select: assert property (lim[0] == (s_q.ctrl.fast ? 24'(FLT_FAST)
      : 24'(FLT_SLOW)) && lim[1] == lim[0]) else $error("up/down filter mismatch");
   chk_reset_fixed: assert property (lim[2] == 24'(RST_FLT))
      else $error("reset filter not fixed");
   chk_quant_hold: assert property (s_q.ctrl.mode == urg_pkg::MODE_INT && !qual[0]
      |=> s_q.qc_up == '0) else $error("timer ran without input");
   chk_net_cancel: assert property (s_q.st == urg_pkg::URG_RUN && !rst_ev
      && s_q.pend_up != '0 && s_q.pend_dn != '0 && s_d.ctrl.ovr == s_q.ctrl.ovr
      |=> $stable(s_q.pos)) else $error("opposing steps did not cancel");
   chk_keep_rule: assert property (s_q.keep_ok |-> $past(s_q.ctrl.mode)
      == urg_pkg::MODE_INT || $past(s_q.pre) == 9'h001) else $error("bad retention");
   chk_preset_load: assert property (s_q.st == urg_pkg::URG_RUN && rst_ev
      && !s_q.ctrl.ovr |=> s_q.pos == 12'($past(s_q.pset))) else $error("preset not loaded");
   chk_pos_bounds: assert property (s_q.st == urg_pkg::URG_RUN |-> s_q.pos
      >= (s_q.ctrl.ovr ? -12'sd30 : 12'sd0) || $changed(s_q.ctrl.ovr))
      else $error("position below limit");
   chk_out_ceiling: assert property (s_q.out_ua <= 16'(urg_pkg::OUT_MAX_UA))
      else $error("output above 20.5 mA");
   chk_span_legal: assert property ((s_q.shi > s_q.slo ? s_q.shi - s_q.slo
      : s_q.slo - s_q.shi) >= 15'(urg_pkg::SPAN_MIN_UA)) else $error("span too small");
   chk_step_size: assert property (s_q.st == urg_pkg::URG_RUN && !rst_ev
      && s_d.ctrl.ovr == s_q.ctrl.ovr |=> s_q.pos - $past(s_q.pos) inside {-12'sd1,
      12'sd0, 12'sd1}) else $error("position jumped");
   chk_bus_answer: assert property ((avs_read || avs_write) && s_q.wt
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");

   cov_reset_load: cover property (s_q.st == urg_pkg::URG_RUN && rst_ev);
   cov_full_span: cover property (s_q.pos == 12'sd1000);
   cov_enc_down: cover property (s_q.ctrl.mode == urg_pkg::MODE_ENC && ev_dn);
   cov_overrange: cover property (s_q.pos > 12'sd1000);
endmodule

// ---- verif/urg_src.sv ----
// Purpose: Field side model: switches, pulse source and encoder.
// Assumes: Pins idle low through pull-downs.
// Notes:   The bench calls the tasks.
`timescale 1ns/1ns
module urg_src (
   input  wire logic clk,
   output logic      up_in,
   output logic      dn_in,
   output logic      rst_in,
   output logic      key_up,
   output logic      key_dn
);
   initial {key_dn, key_up, rst_in, dn_in, up_in} = 5'h00;
   task automatic hold(input logic [4:0] m, input int n);
      @(posedge clk);
      {key_dn, key_up, rst_in, dn_in, up_in} <= m;
      repeat (n) @(posedge clk);
      {key_dn, key_up, rst_in, dn_in, up_in} <= 5'h00;
   endtask
   task automatic enc(input logic b, input int n);
      hold({3'h0, b, 1'b0}, n);
      hold({3'h0, b, 1'b1}, n);
      hold({3'h0, b, 1'b0}, n);
   endtask
endmodule

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench of the ramp generator core.
// Assumes: Shortened filter and quantum counts.
// Notes:   Register access over Avalon-MM.
`timescale 1ns/1ns
module testbench;
   logic               clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic               pup_hold, nv_valid, keep_ok, up_in, dn_in, rst_in, key_up, key_dn;
   logic [7:0]         avs_address;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_writedata, avs_readdata, rd;
   logic signed [11:0] nv_pos, pos_out;
   logic [15:0]        out_ua;
   int                 error_cnt = 0;
   int                 checks = 0;

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   urg_top #(.FLT_SLOW(20), .FLT_FAST(5), .RST_FLT(30), .QUANT(10)) dut (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .up_in(up_in),
      .dn_in(dn_in), .rst_in(rst_in), .key_up(key_up), .key_dn(key_dn), .pup_hold(pup_hold),
      .nv_valid(nv_valid), .nv_pos(nv_pos), .pos_out(pos_out), .out_ua(out_ua),
      .keep_ok(keep_ok));
   urg_src src (.clk(clk), .up_in(up_in), .dn_in(dn_in), .rst_in(rst_in),
      .key_up(key_up), .key_dn(key_dn));

   task automatic end_sim;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
      begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask

   // Waits up to n cycles for the position, then compares it.
   task automatic pchk(input logic [31:0] exp, input int n);
      int i;
      i = 0;
      while ({{20{pos_out[11]}}, pos_out} !== exp && i < n)
      begin
         @(posedge clk);
         i++;
      end
      cmp({{20{pos_out[11]}}, pos_out}, exp);
   endtask

   initial
   begin
      #400000;
      error_cnt++;
      end_sim;
   end

   initial
   begin
      {reset_n, avs_read, avs_write, pup_hold, nv_valid} = 5'h00;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      nv_pos = 12'sh000;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rchk(urg_pkg::REG_CTRL, 32'h1);
      rchk(urg_pkg::REG_PRE, 32'h1);
      rchk(urg_pkg::REG_SLO, 32'h0FA0);
      rchk(8'h30, 32'h0);
      $display("test reset done");
      bus(1'b1, urg_pkg::REG_CTRL, 32'h2);
      bus(1'b1, urg_pkg::REG_UPC, 32'h2);
      bus(1'b1, urg_pkg::REG_DNC, 32'h2);
      src.hold(5'h01, 40);
      pchk(32'd500, 800);
      src.hold(5'h01, 10);
      src.hold(5'h08, 40);
      repeat (600) @(posedge clk);
      pchk(32'd500, 0);
      pchk(32'd500, 0);
      src.hold(5'h03, 40);
      repeat (600) @(posedge clk);
      pchk(32'd500, 0);
      src.hold(5'h02, 40);
      pchk(32'd0, 800);
      cmp(keep_ok, 1'b1);
      bus(1'b1, urg_pkg::REG_PRE, 32'h2);
      rchk(urg_pkg::REG_STAT, 32'h0);
      $display("test pulse done");
      bus(1'b1, urg_pkg::REG_PRE, 32'd257);
      rchk(urg_pkg::REG_PRE, 32'h2);
      rchk(urg_pkg::REG_STAT, 32'h8);
      bus(1'b1, urg_pkg::REG_STAT, 32'h8);
      bus(1'b1, urg_pkg::REG_SHI, 32'd7000);
      rchk(urg_pkg::REG_SHI, 32'd20000);
      bus(1'b1, urg_pkg::REG_CTRL, 32'h0);
      rchk(urg_pkg::REG_CTRL, 32'h2);
      bus(1'b1, urg_pkg::REG_UPT, 32'h0);
      rchk(urg_pkg::REG_UPT, 32'd100);
      bus(1'b1, urg_pkg::REG_DNT, 32'd9999991);
      rchk(urg_pkg::REG_DNT, 32'd100);
      bus(1'b1, urg_pkg::REG_STAT, 32'h8);
      bus(1'b1, urg_pkg::REG_PRE, 32'h1);
      $display("test refusal done");
      bus(1'b1, urg_pkg::REG_CTRL, 32'h7);
      src.enc(1'b0, 10);
      pchk(32'd500, 800);
      src.enc(1'b1, 10);
      pchk(32'd0, 800);
      $display("test encoder done");
      bus(1'b1, urg_pkg::REG_PSET, 32'd250);
      src.hold(5'h04, 20);
      repeat (100) @(posedge clk);
      pchk(32'd0, 0);
      src.hold(5'h04, 40);
      pchk(32'd250, 100);
      $display("test preset done");
      bus(1'b1, urg_pkg::REG_CTRL, 32'h1D);
      bus(1'b1, urg_pkg::REG_UPT, 32'h1);
      bus(1'b1, urg_pkg::REG_DNT, 32'h1);
      src.hold(5'h03, 3000);
      pchk(32'd250, 0);
      src.hold(5'h10, 4000);
      pchk(32'hFFFFFFE2, 100);
      @(posedge clk);
      @(posedge clk);
      cmp({16'h0, out_ua}, 32'd3520);
      $display("test timed done");
      reset_n <= 1'b0;
      pup_hold <= 1'b1;
      nv_valid <= 1'b1;
      nv_pos <= 12'sd321;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      pchk(32'd321, 20);
      $display("test restore done");
      end_sim;
   end
endmodule
